// file: test_tmr_timer_two.sv
`timescale 1ns/10ps
module test_tmr_timer_two;
    // Short register address aliases
    localparam logic [7:0] AC = tmr_pkg::ADDR_CONTROL;
    localparam logic [7:0] AM = tmr_pkg::ADDR_MODE;
    localparam logic [7:0] ARL = tmr_pkg::ADDR_RELOAD_LOW;
    localparam logic [7:0] ARH = tmr_pkg::ADDR_RELOAD_HIGH;
    localparam logic [7:0] ACL = tmr_pkg::ADDR_COUNT_LOW;
    localparam logic [7:0] ACH = tmr_pkg::ADDR_COUNT_HIGH;
    // Bench drives and design outputs
    logic ref_clk = 1'b0;
    logic arst_n = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack, pin_o, oe, rx, tx, irq, cnt, trig, t1, pin_w;
    int err_total = 0;
    int comparisons = 0;
    int rx_n = 0;
    int tx_n = 0;
    logic [7:0] exp_q[$];

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    // Pin level: ours while driving, partner otherwise
    assign pin_w = oe ? pin_o : cnt;

    tmr_timer_two i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .count_clock_pin_i(pin_w),
        .count_clock_pin_o(pin_o), .count_clock_pin_oe(oe),
        .trigger_direction_pin_i(trig), .timer_one_overflow_i(t1),
        .serial_rx_clock_o(rx), .serial_tx_clock_o(tx), .timer_irq_o(irq)
    );
    tmr_pin_model i_pm (.clk(ref_clk), .count_o(cnt), .trig_o(trig), .t1_ovf_o(t1));

    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    // Single classic cycle, released at the ack edge or on a 41-clock timeout
    task automatic x(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        sel <= s;
        dat <= {24'h00_0000, d};
        do @(posedge ref_clk); while (ack !== 1'b1 && n++ < 40);
        cyc <= 1'b0;
        stb <= 1'b0;
        // A missing ack is a mismatch; wait off the edge so outputs are settled
        if (ack !== 1'b1) err_total++;
        @(negedge ref_clk);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        x(1'b1, a, d, 4'h1);
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        x(1'b0, a, 8'h00, 4'h1);
    endtask
    // Clocks until the clock-out level next changes
    task automatic hl(output int n);
        logic v;
        v = pin_o;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pin_o === v && n < 300);
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Read data matched oldest note first; serial pulses counted
    always @(posedge ref_clk) begin
        if (ack === 1'b1 && we === 1'b0) ck("read", {24'h00_0000, exp_q.pop_front()}, dat_o);
        rx_n <= rx_n + int'(rx === 1'b1);
        tx_n <= tx_n + int'(tx === 1'b1);
    end
    // Whole run is a few hundred clocks
    initial begin
        repeat (30000) @(posedge ref_clk);
        err_total++;
        close_out();
    end

    initial begin
        logic [15:0] rv, v1, rl;
        int p, n, rb, tb, pb;
        // Falling reset at time zero so every flop starts known
        arst_n <= 1'b0;
        void'($urandom(62170));
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 6; i++) r(AC + 8'(i), 8'h00);
        w(8'hc0, 8'h5a);
        r(8'hc0, 8'h00);
        ck("oe", 0, oe);
        rv = 16'($urandom) & 16'h7fff;
        v1 = rv + 16'h0001;
        w(ARL, rv[7:0]);
        w(ARH, rv[15:8]);
        x(1'b1, ARL, ~rv[7:0], 4'h0);
        r(ARL, rv[7:0]);
        w(AM, 8'h02);
        ck("oe", 1, oe);
        w(AM, 8'h00);
        $display("end regs");
        // Three ticks from FFFE: overflow then reload plus one
        w(ACL, 8'hfe);
        w(ACH, 8'hff);
        w(AC, 8'h04);
        w(AC, 8'h80);
        r(ACL, v1[7:0]);
        r(ACH, v1[15:8]);
        r(AC, 8'h80);
        ck("irq", 1, irq);
        w(AC, 8'h00);
        ck("irq", 0, irq);
        // Serial clocking: forced reload, no flag, pulses out
        rb = rx_n;
        tb = tx_n;
        w(ACL, 8'hfe);
        w(ACH, 8'hff);
        w(AC, 8'h35);
        w(AC, 8'h31);
        r(ACL, v1[7:0]);
        r(AC, 8'h31);
        ck("rx", 1, rx_n - rb);
        ck("tx", 1, tx_n - tb);
        w(AC, 8'h00);
        rb = rx_n;
        pb = i_pm.t1_n;
        i_pm.t1_en <= 1'b1;
        repeat (20) @(posedge ref_clk);
        i_pm.t1_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ck("rx t1", i_pm.t1_n - pb, rx_n - rb);
        $display("end serial");
        // Counter mode on pin edges, then trigger events
        w(ACL, 8'h00);
        w(ACH, 8'h00);
        w(AC, 8'h06);
        i_pm.pulse(1'b0, 5);
        r(ACL, 8'h05);
        w(AC, 8'h07);
        i_pm.pulse(1'b1, 1);
        r(AC, 8'h07);
        w(AC, 8'h0f);
        i_pm.pulse(1'b1, 1);
        r(ARL, 8'h05);
        r(ARH, 8'h00);
        r(AC, 8'h4f);
        r(ACL, 8'h05);
        ck("irq", 1, irq);
        w(AC, 8'h00);
        $display("end capture");
        // Up/down: two down ticks wrap to FFFF, one up reloads
        w(ARL, rv[7:0]);
        w(ARH, rv[15:8]);
        w(AM, 8'h01);
        w(ACL, v1[7:0]);
        w(ACH, v1[15:8]);
        i_pm.trig_o <= 1'b0;
        w(AC, 8'h06);
        i_pm.pulse(1'b0, 2);
        r(ACL, 8'hff);
        r(ACH, 8'hff);
        r(AC, 8'hc6);
        w(AC, 8'h46);
        ck("irq", 0, irq);
        i_pm.trig_o <= 1'b1;
        i_pm.pulse(1'b0, 1);
        r(ACL, rv[7:0]);
        r(AC, 8'h86);
        w(AC, 8'h00);
        $display("end updown");
        // Clock-out, set up in the prescribed order
        rl = 16'hfff0 + 16'($urandom_range(13));
        p = 4 * (65536 - int'(rl));
        w(AM, 8'h02);
        w(AC, 8'h00);
        w(ARL, rl[7:0]);
        w(ARH, 8'hff);
        w(ACL, rl[7:0]);
        w(ACH, 8'hff);
        w(AC, 8'h04);
        hl(n);
        hl(n);
        ck("high", p / 2, n);
        hl(n);
        ck("low", p / 2, n);
        r(AC, 8'h04);
        ck("irq", 0, irq);
        w(AC, 8'h00);
        w(AM, 8'h00);
        $display("end clockout");
        close_out();
    end
endmodule

// file: tmr_edge_detect.sv
`timescale 1ns/10ps
// Falling-edge detector on a pin taken as synchronous
module tmr_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and event
    input wire logic pin_i,
    output logic fall_o
);
    logic last_q;

    // Reset high, so a pin held low at start gives one edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b1;
        end else begin
            last_q <= pin_i;
        end
    end

    assign fall_o = last_q & ~pin_i;
endmodule

// file: tmr_pin_model.sv
`timescale 1ns/10ps
// Far side: count pin, trigger pin and timer one overflow
module tmr_pin_model (
    // Clock
    input wire logic clk,
    // Toward the timer
    output logic count_o,
    output logic trig_o,
    output logic t1_ovf_o
);
    logic t1_en = 1'b0;
    int t1_n = 0;
    // Idle count and trigger lines sit at their pull-up level; overflow idles low
    initial begin
        count_o = 1'b1;
        trig_o = 1'b1;
        t1_ovf_o = 1'b0;
    end
    // Overflow every other clock, counted for the bench
    always @(posedge clk) begin
        t1_ovf_o <= t1_en && !t1_ovf_o;
        t1_n <= t1_n + int'(t1_ovf_o);
    end
    // One-clock low pulses; trigger level doubles as direction
    task automatic pulse(input logic on_trig, input int n);
        repeat (n) begin
            @(posedge clk);
            if (on_trig) trig_o <= 1'b0;
            else count_o <= 1'b0;
            @(posedge clk);
            if (on_trig) trig_o <= 1'b1;
            else count_o <= 1'b1;
        end
    endtask
endmodule

// file: tmr_pkg.sv
package tmr_pkg;
    // Byte addresses on the bus (consecutive, one per register)
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_MODE = 8'hc9;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
    // Control register fields
    localparam int CTL_OVERFLOW = 7;
    localparam int CTL_EXTERNAL = 6;
    localparam int CTL_RX_SEL = 5;
    localparam int CTL_TX_SEL = 4;
    localparam int CTL_EXT_EN = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_COUNTER = 1;
    localparam int CTL_CAPTURE = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Mode register fields
    localparam int MODE_DOWN_EN = 0;
    localparam int MODE_OUT_EN = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// file: tmr_timer_two.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
module tmr_timer_two (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Count clock pin, two-way
    input wire logic count_clock_pin_i,
    output logic count_clock_pin_o,
    output logic count_clock_pin_oe,
    // Trigger and direction pin
    input wire logic trigger_direction_pin_i,
    // Serial port side
    input wire logic timer_one_overflow_i,
    output logic serial_rx_clock_o,
    output logic serial_tx_clock_o,
    // Interrupt request line to the core controller
    output logic timer_irq_o
);
    logic rst_meta_q;
    logic rst_q;
    logic rst_n;
    logic wr_stb;
    logic [7:0] wr_adr;
    logic [7:0] wr_dat;
    logic [7:0] rd_dat;
    logic count_fall;
    logic trig_fall;
    logic [7:0] control_q;
    logic [1:0] mode_q;
    logic [7:0] count_low_byte_q;
    logic [7:0] count_high_byte_q;
    logic [7:0] reload_low_byte_q;
    logic [7:0] reload_high_byte_q;
    logic half_q;
    logic clk_out_q;
    logic rx_q;
    logic tx_q;
    logic serial_mode;
    logic out_mode;
    logic updown;
    logic tick;
    logic count_up;
    logic low_carry;
    logic wrap_up;
    logic wrap_down;
    logic overflow_evt;
    logic trig_evt;
    logic capture_evt;
    logic trig_reload_evt;
    logic set_overflow;
    logic set_external;
    logic toggle_external;
    logic wr_control;

    // Reset released through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_q;

    tmr_wb_slave u_bus (
        .clk(ref_clk),
        .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wr_stb_o(wr_stb),
        .wr_adr_o(wr_adr),
        .wr_dat_o(wr_dat),
        .rd_dat_i(rd_dat)
    );

    // External count input edges; output-enable blocks own clock feeding back
    tmr_edge_detect u_count_edge (
        .clk(ref_clk),
        .rst_n(rst_n),
        .pin_i(count_clock_pin_i),
        .fall_o(count_fall)
    );

    tmr_edge_detect u_trig_edge (
        .clk(ref_clk),
        .rst_n(rst_n),
        .pin_i(trigger_direction_pin_i),
        .fall_o(trig_fall)
    );

    // Mode decode
    assign serial_mode = control_q[tmr_pkg::CTL_RX_SEL] | control_q[tmr_pkg::CTL_TX_SEL];
    assign out_mode = mode_q[tmr_pkg::MODE_OUT_EN];
    assign updown = mode_q[tmr_pkg::MODE_DOWN_EN] & ~serial_mode & ~out_mode
        & ~control_q[tmr_pkg::CTL_CAPTURE];
    assign count_up = ~updown | trigger_direction_pin_i;

    // Count source: clock-out mode ticks every other clock
    always_comb begin
        if (!control_q[tmr_pkg::CTL_RUN]) begin
            tick = 1'b0;
        end else if (out_mode) begin
            tick = half_q;
        end else if (control_q[tmr_pkg::CTL_COUNTER]) begin
            tick = count_fall;
        end else begin
            tick = 1'b1;
        end
    end

    // Wrap detection for either direction
    assign low_carry = count_low_byte_q == 8'hff;
    assign wrap_up = tick & count_up & low_carry & (count_high_byte_q == 8'hff);
    assign wrap_down = tick & ~count_up & ({count_high_byte_q, count_low_byte_q}
        == {reload_high_byte_q, reload_low_byte_q});
    assign overflow_evt = wrap_up | wrap_down;

    // Trigger edges only when enabled and not baud clocking
    assign trig_evt = trig_fall & control_q[tmr_pkg::CTL_EXT_EN] & ~serial_mode
        & ~updown;
    assign capture_evt = trig_evt & control_q[tmr_pkg::CTL_CAPTURE];
    assign trig_reload_evt = trig_evt & ~control_q[tmr_pkg::CTL_CAPTURE];

    // Flag events; clock-out and baud overflows raise nothing
    assign set_overflow = overflow_evt & ~serial_mode & ~out_mode;
    assign set_external = trig_evt;
    assign toggle_external = updown & overflow_evt;
    assign wr_control = wr_stb & (wr_adr == tmr_pkg::ADDR_CONTROL);

    // Control register; hardware sets win over a software clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= tmr_pkg::CONTROL_RESET;
        end else begin
            if (wr_control) begin
                control_q[5:0] <= wr_dat[5:0];
            end
            if (set_overflow) begin
                control_q[tmr_pkg::CTL_OVERFLOW] <= 1'b1;
            end else if (wr_control) begin
                control_q[tmr_pkg::CTL_OVERFLOW] <= wr_dat[tmr_pkg::CTL_OVERFLOW];
            end
            if (set_external) begin
                control_q[tmr_pkg::CTL_EXTERNAL] <= 1'b1;
            end else if (toggle_external) begin
                control_q[tmr_pkg::CTL_EXTERNAL] <= ~control_q[tmr_pkg::CTL_EXTERNAL];
            end else if (wr_control) begin
                control_q[tmr_pkg::CTL_EXTERNAL] <= wr_dat[tmr_pkg::CTL_EXTERNAL];
            end
        end
    end

    // Mode register, two bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= tmr_pkg::MODE_RESET;
        end else if (wr_stb && wr_adr == tmr_pkg::ADDR_MODE) begin
            mode_q <= wr_dat[1:0];
        end
    end

    // Reload/capture registers, shared by baud and clock-out
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_low_byte_q <= tmr_pkg::WORD_RESET[7:0];
            reload_high_byte_q <= tmr_pkg::WORD_RESET[15:8];
        end else if (capture_evt) begin
            reload_low_byte_q <= count_low_byte_q;
            reload_high_byte_q <= count_high_byte_q;
        end else begin
            if (wr_stb && wr_adr == tmr_pkg::ADDR_RELOAD_LOW) begin
                reload_low_byte_q <= wr_dat;
            end
            if (wr_stb && wr_adr == tmr_pkg::ADDR_RELOAD_HIGH) begin
                reload_high_byte_q <= wr_dat;
            end
        end
    end

    // Count bytes; low carry steps high. Software writes lose to hardware
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_low_byte_q <= tmr_pkg::WORD_RESET[7:0];
            count_high_byte_q <= tmr_pkg::WORD_RESET[15:8];
        end else if (wrap_up || trig_reload_evt) begin
            count_low_byte_q <= reload_low_byte_q;
            count_high_byte_q <= reload_high_byte_q;
        end else if (wrap_down) begin
            count_low_byte_q <= tmr_pkg::COUNT_TOP[7:0];
            count_high_byte_q <= tmr_pkg::COUNT_TOP[15:8];
        end else if (tick && count_up) begin
            count_low_byte_q <= count_low_byte_q + 8'h01;
            if (low_carry) begin
                count_high_byte_q <= count_high_byte_q + 8'h01;
            end
        end else if (tick) begin
            count_low_byte_q <= count_low_byte_q - 8'h01;
            if (count_low_byte_q == 8'h00) begin
                count_high_byte_q <= count_high_byte_q - 8'h01;
            end
        end else begin
            if (wr_stb && wr_adr == tmr_pkg::ADDR_COUNT_LOW) begin
                count_low_byte_q <= wr_dat;
            end
            if (wr_stb && wr_adr == tmr_pkg::ADDR_COUNT_HIGH) begin
                count_high_byte_q <= wr_dat;
            end
        end
    end

    // Half-rate prescaler and output toggle on each overflow
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
            clk_out_q <= 1'b0;
        end else begin
            half_q <= out_mode & control_q[tmr_pkg::CTL_RUN] & ~half_q;
            if (out_mode && wrap_up) begin
                clk_out_q <= ~clk_out_q;
            end
        end
    end

    // Serial clocks: overflow pulse of timer two or timer one
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= 1'b0;
            tx_q <= 1'b0;
        end else begin
            rx_q <= control_q[tmr_pkg::CTL_RX_SEL] ? wrap_up : timer_one_overflow_i;
            tx_q <= control_q[tmr_pkg::CTL_TX_SEL] ? wrap_up : timer_one_overflow_i;
        end
    end
    assign serial_rx_clock_o = rx_q;
    assign serial_tx_clock_o = tx_q;

    // Pin drive; a half-period is two clocks per step, so full period 4*(65536-reload)
    assign count_clock_pin_o = clk_out_q;
    assign count_clock_pin_oe = out_mode;
    // Up/down external toggles give no request
    assign timer_irq_o = control_q[tmr_pkg::CTL_OVERFLOW]
        | (control_q[tmr_pkg::CTL_EXTERNAL] & ~updown);

    // Read mux, unmapped reads return zero
    always_comb begin
        case (wr_adr)
            tmr_pkg::ADDR_CONTROL: rd_dat = control_q;
            tmr_pkg::ADDR_MODE: rd_dat = {6'h00, mode_q};
            tmr_pkg::ADDR_RELOAD_LOW: rd_dat = reload_low_byte_q;
            tmr_pkg::ADDR_RELOAD_HIGH: rd_dat = reload_high_byte_q;
            tmr_pkg::ADDR_COUNT_LOW: rd_dat = count_low_byte_q;
            tmr_pkg::ADDR_COUNT_HIGH: rd_dat = count_high_byte_q;
            default: rd_dat = 8'h00;
        endcase
    end
endmodule

// file: tmr_timer_two_properties.sv
`timescale 1ns/10ps
// Port-level checks on the timer's bus, pins and interrupt
module tmr_timer_two_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and interrupt
    input wire logic count_clock_pin_o,
    input wire logic count_clock_pin_oe,
    input wire logic timer_irq_o
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Bus answers exactly one cycle after the request
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    // Reset is asynchronous, so this one runs through reset
    AST_OE_RESET: assert property (disable iff (1'b0) !arst_n |-> !count_clock_pin_oe)
        else $error("pin driven in reset");
    // Only a register write may move the enable or drop the interrupt request
    AST_OE_WRITE: assert property ($changed(count_clock_pin_oe) |-> $past(wb_ack_o && wb_we_i))
        else $error("enable moved alone");
    AST_IRQ_CLEAR: assert property ($fell(timer_irq_o) |-> $past(wb_ack_o && wb_we_i))
        else $error("flag cleared by hardware");
    // Half-rate stepping keeps each level for two clocks at least
    AST_PIN_HOLD: assert property ($changed(count_clock_pin_o) |=> $stable(count_clock_pin_o))
        else $error("clock out too fast");
endmodule

bind tmr_timer_two tmr_timer_two_properties i_props (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .count_clock_pin_o(count_clock_pin_o), .count_clock_pin_oe(count_clock_pin_oe),
    .timer_irq_o(timer_irq_o)
);

// file: tmr_wb_slave.sv
`timescale 1ns/10ps
// Classic Wishbone front end, one registered ack per access, a cycle after the request
module tmr_wb_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Register side
    output logic wr_stb_o,
    output logic [7:0] wr_adr_o,
    output logic [7:0] wr_dat_o,
    input wire logic [7:0] rd_dat_i
);
    logic ack_q;
    logic [31:0] dat_q;

    // Ack one cycle after request; cleared next cycle to end handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // Read data captured with the ack, upper bits read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_q <= 32'h0000_0000;
        end else begin
            dat_q <= {24'h00_0000, rd_dat_i};
        end
    end

    // Write lands on the acking edge, only lane 0 carries data
    assign wr_stb_o = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
    assign wr_adr_o = wb_adr_i;
    assign wr_dat_o = wb_dat_i[7:0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule
